// file: hw/rsl_pkg.sv
// Constants and types shared by the reset-state loader files.
// Assumes an 8-bit register view and a 13-bit program counter in the core.
package rsl_pkg;

  // Program counter width and load targets
  localparam int unsigned PC_W         = 13;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam logic [12:0] PC_STEP      = 13'h0001;

  // Processor status layout
  localparam int unsigned ST_TO_BIT    = 4;
  localparam int unsigned ST_PD_BIT    = 3;
  localparam logic [7:0]  ST_BANK_MASK = 8'he0;
  localparam logic [7:0]  ST_WR_MASK   = 8'he7;
  localparam logic [7:0]  ST_RESET     = 8'h18;

  // Power/reset status layout
  localparam int unsigned POWER_RESET_STATUS_REG_BOR_BIT   = 0;
  localparam int unsigned POWER_RESET_STATUS_REG_POR_BIT   = 1;
  localparam int unsigned POWER_RESET_STATUS_REG_PER_BIT   = 2;
  localparam int unsigned POWER_RESET_STATUS_REG_CFG_BIT   = 7;
  localparam logic [7:0]  POWER_RESET_STATUS_REG_IMPL_MASK = 8'h07;
  localparam logic [7:0]  POWER_RESET_STATUS_REG_RESET     = 8'h04;

  // Interrupt control and peripheral flag layouts
  localparam int unsigned GIE_BIT          = 7;
  localparam logic [7:0]  IRQCON_FLAG_MASK = 8'h07;
  localparam logic [7:0]  IRQCON_KEEP_MASK = 8'h01;
  localparam logic [7:0]  PIR_IMPL_MASK    = 8'h40;
  localparam logic [7:0]  PORTA_IMPL_MASK  = 8'h1f;
  localparam logic [7:0]  ALL_ONES         = 8'hff;
  localparam logic [7:0]  ALL_ZERO         = 8'h00;

  // Register port map
  localparam logic [3:0] ADDR_STATUS    = 4'h0;
  localparam logic [3:0] ADDR_POWER_RESET_STATUS_REG      = 4'h1;
  localparam logic [3:0] ADDR_IRQCON    = 4'h2;
  localparam logic [3:0] ADDR_PIR       = 4'h3;
  localparam logic [3:0] ADDR_PIE       = 4'h4;
  localparam logic [3:0] ADDR_OPTION    = 4'h5;
  localparam logic [3:0] ADDR_PORTA_DIR = 4'h6;
  localparam logic [3:0] ADDR_PORTB_DIR = 4'h7;
  localparam logic [3:0] ADDR_EV_STATUS = 4'h8;
  localparam logic [3:0] ADDR_EV_MASK   = 4'h9;

  // Event status bit positions
  localparam int unsigned EV_POR      = 0;
  localparam int unsigned EV_BOR      = 1;
  localparam int unsigned EV_PARITY   = 2;
  localparam int unsigned EV_EXT      = 3;
  localparam int unsigned EV_WDT_RST  = 4;
  localparam int unsigned EV_WDT_WAKE = 5;
  localparam int unsigned EV_IRQ_WAKE = 6;
  localparam logic [7:0]  EV_MASK     = 8'h7f;

  // Reset or wake-up cause picked this cycle
  typedef enum {
    cause_none,
    cause_por,
    cause_bor,
    cause_parity,
    cause_ext_run,
    cause_ext_sleep,
    cause_wdt_reset,
    cause_wdt_wake,
    cause_irq_wake
  } rsl_cause_t;

endpackage

// file: hw/rsl_cause_sel.sv
// Priority selection of the reset or wake-up cause for one cycle.
// Assumes every cause input is a one-cycle request synchronous to the clock.
`timescale 1ns/10ps
module rsl_cause_sel
  import rsl_pkg::*;
#(
  parameter bit HAS_POWER_RESET_STATUS_REG = 1'b1
) (
  // Cause requests
  input  wire logic por_i,
  input  wire logic brownout_i,
  input  wire logic parity_err_i,
  input  wire logic external_reset_pin_i,
  input  wire logic wdt_timeout_i,
  input  wire logic irq_wake_i,
  // Core state
  input  wire logic asleep_i,
  // Selected cause
  output rsl_cause_t cause_o
);

  wire logic bor_live;
  assign bor_live = brownout_i & HAS_POWER_RESET_STATUS_REG;

  // Power-on first, then brown-out, parity, pin, watchdog, interrupt
  assign cause_o = por_i                ? cause_por :
                   bor_live             ? cause_bor :
                   parity_err_i         ? cause_parity :
                   external_reset_pin_i ? (asleep_i ? cause_ext_sleep : cause_ext_run) :
                   wdt_timeout_i        ? (asleep_i ? cause_wdt_wake : cause_wdt_reset) :
                   (irq_wake_i & asleep_i) ? cause_irq_wake : cause_none;

endmodule // rsl_cause_sel

// file: hw/rsl_loader.sv
// Reset-state loader: decides PC, status and flag registers after each reset or wake-up.
// Assumes one-cycle cause requests from the detectors and a core that obeys pc_load_o.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module rsl_loader
  import rsl_pkg::*;
#(
  parameter bit HAS_POWER_RESET_STATUS_REG = 1'b1
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  // Cause detectors
  input  wire logic            por_i,
  input  wire logic            brownout_i,
  input  wire logic            parity_err_i,
  input  wire logic            external_reset_pin_i,
  input  wire logic            wdt_timeout_i,
  input  wire logic            irq_wake_i,
  // Core state
  input  wire logic            asleep_i,
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic            parity_en_cfg_i,
  // Flags of the waking source
  input  wire logic [7:0]      wake_irq_flags_i,
  input  wire logic [7:0]      wake_periph_flags_i,
  // Register port
  input  wire logic [3:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [7:0]      rdata_o,
  // Program counter load
  output logic                 pc_load_o,
  output logic      [PC_W-1:0] pc_value_o,
  // Register contents
  output logic      [7:0]      status_o,
  output logic      [7:0]      power_reset_status_reg_o,
  output logic      [7:0]      irq_control_reg_o,
  output logic      [7:0]      periph_irq_flag_reg_o,
  output logic      [7:0]      periph_irq_enable_reg_o,
  output logic      [7:0]      option_o,
  output logic      [7:0]      port_a_direction_o,
  output logic      [7:0]      port_b_direction_o,
  // Interrupt
  output logic                 irq_o
);

  // Next instruction address
  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    pc_inc = pc + PC_STEP;
  endfunction

  // Merge a written byte into a register under a write mask
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction

  rsl_cause_t cause;
  logic [7:0] ev_status;
  logic [7:0] ev_mask;
  logic [7:0] next_status;
  logic [7:0] next_power_reset_status_reg;
  logic [7:0] next_irqcon;
  logic [7:0] next_pir;
  logic [7:0] next_pie;
  logic [7:0] next_option;
  logic [7:0] next_porta;
  logic [7:0] next_portb;
  logic [7:0] ev_set;

  // Cause selection
  rsl_cause_sel #(
    .HAS_POWER_RESET_STATUS_REG (HAS_POWER_RESET_STATUS_REG)
  ) u_cause (
    .por_i                (por_i),
    .brownout_i           (brownout_i),
    .parity_err_i         (parity_err_i),
    .external_reset_pin_i (external_reset_pin_i),
    .wdt_timeout_i        (wdt_timeout_i),
    .irq_wake_i           (irq_wake_i),
    .asleep_i             (asleep_i),
    .cause_o              (cause)
  );

  // Address decode for writes
  wire logic wr_status = wr_i && (addr_i == ADDR_STATUS);
  wire logic wr_power_reset_status_reg   = wr_i && (addr_i == ADDR_POWER_RESET_STATUS_REG);
  wire logic wr_irqcon = wr_i && (addr_i == ADDR_IRQCON);
  wire logic wr_pir    = wr_i && (addr_i == ADDR_PIR);
  wire logic wr_pie    = wr_i && (addr_i == ADDR_PIE);
  wire logic wr_option = wr_i && (addr_i == ADDR_OPTION);
  wire logic wr_porta  = wr_i && (addr_i == ADDR_PORTA_DIR);
  wire logic wr_portb  = wr_i && (addr_i == ADDR_PORTB_DIR);
  wire logic wr_evst   = wr_i && (addr_i == ADDR_EV_STATUS);
  wire logic wr_evmask = wr_i && (addr_i == ADDR_EV_MASK);

  // Cause classes
  wire logic global_irq_enable = irq_control_reg_o[GIE_BIT];
  wire logic is_wake  = (cause == cause_wdt_wake) || (cause == cause_irq_wake);
  wire logic is_reset = (cause != cause_none) && !is_wake;

  wire logic [PC_W-1:0] wake_target = ((cause == cause_irq_wake) && global_irq_enable) ? IRQ_VECTOR : pc_inc(pc_i);
  wire logic [PC_W-1:0] next_pc     = is_wake ? wake_target : RESET_VECTOR;

  // Software-written values, before any cause is applied
  wire logic [7:0] sw_status = wr_status ? merge(status_o, wdata_i, ST_WR_MASK) : status_o;
  wire logic [7:0] sw_power_reset_status_reg   = wr_power_reset_status_reg ? (wdata_i & POWER_RESET_STATUS_REG_IMPL_MASK) : power_reset_status_reg_o;
  wire logic [7:0] sw_irqcon = wr_irqcon ? wdata_i : irq_control_reg_o;
  wire logic [7:0] sw_pir    = wr_pir ? (wdata_i & PIR_IMPL_MASK) : periph_irq_flag_reg_o;

  // waking source flags, masked to implemented flag bits
  wire logic [7:0] wake_irq_bits = is_wake ? (wake_irq_flags_i & IRQCON_FLAG_MASK) : ALL_ZERO;
  wire logic [7:0] wake_pir_bits = is_wake ? (wake_periph_flags_i & PIR_IMPL_MASK) : ALL_ZERO;

  // Processor status update per cause
  always_comb begin
    next_status = sw_status;
    case (cause)
      cause_por, cause_bor: begin
        next_status = (sw_status & ~ST_BANK_MASK) | ST_RESET;
      end
      cause_ext_run: begin
        next_status = sw_status & ~ST_BANK_MASK;
      end
      cause_ext_sleep: begin
        next_status = sw_status & ~ST_BANK_MASK;
        next_status[ST_TO_BIT] = 1'b1;
        next_status[ST_PD_BIT] = 1'b0;
      end
      cause_wdt_reset: begin
        next_status = sw_status & ~ST_BANK_MASK;
        next_status[ST_TO_BIT] = 1'b0;
        next_status[ST_PD_BIT] = 1'b1;
      end
      cause_wdt_wake: begin
        next_status[ST_TO_BIT] = 1'b0;
        next_status[ST_PD_BIT] = 1'b0;
      end
      cause_irq_wake, cause_parity: begin
        next_status[ST_TO_BIT] = 1'b1;
        next_status[ST_PD_BIT] = 1'b0;
      end
      default: begin
        next_status = sw_status;
      end
    endcase
  end

  // Power/reset status update per cause
  always_comb begin
    next_power_reset_status_reg = sw_power_reset_status_reg;
    case (cause)
      // power-on clears its flag and sets parity flag
      cause_por: begin
        next_power_reset_status_reg[POWER_RESET_STATUS_REG_POR_BIT] = 1'b0;
        next_power_reset_status_reg[POWER_RESET_STATUS_REG_PER_BIT] = 1'b1;
      end
      // brown-out clears only its own flag
      cause_bor: begin
        next_power_reset_status_reg[POWER_RESET_STATUS_REG_BOR_BIT] = 1'b0;
      end
      // parity reset clears only its own flag
      cause_parity: begin
        next_power_reset_status_reg[POWER_RESET_STATUS_REG_PER_BIT] = 1'b0;
      end
      default: begin
        next_power_reset_status_reg = sw_power_reset_status_reg;
      end
    endcase
    // reduced build holds no power flags
    if (!HAS_POWER_RESET_STATUS_REG) begin
      next_power_reset_status_reg = ALL_ZERO;
    end
  end

  // Control and direction registers: reset image, else software, then wake flags
  always_comb begin
    next_irqcon = sw_irqcon | wake_irq_bits;
    next_pir    = sw_pir | wake_pir_bits;
    next_pie    = wr_pie ? (wdata_i & PIR_IMPL_MASK) : periph_irq_enable_reg_o;
    next_option = wr_option ? wdata_i : option_o;
    next_porta  = wr_porta ? (wdata_i & PORTA_IMPL_MASK) : port_a_direction_o;
    next_portb  = wr_portb ? wdata_i : port_b_direction_o;
    // reset image: ones in option and directions, enables cleared
    if (is_reset) begin
      next_irqcon = sw_irqcon & IRQCON_KEEP_MASK;
      next_pir    = ALL_ZERO;
      next_pie    = ALL_ZERO;
      next_option = ALL_ONES;
      next_porta  = PORTA_IMPL_MASK;
      next_portb  = ALL_ONES;
    end
  end

  // Event bits for the interrupt status register
  always_comb begin
    ev_set = ALL_ZERO;
    ev_set[EV_POR]      = (cause == cause_por);
    ev_set[EV_BOR]      = (cause == cause_bor);
    ev_set[EV_PARITY]   = (cause == cause_parity);
    ev_set[EV_EXT]      = (cause == cause_ext_run) || (cause == cause_ext_sleep);
    ev_set[EV_WDT_RST]  = (cause == cause_wdt_reset);
    ev_set[EV_WDT_WAKE] = (cause == cause_wdt_wake);
    ev_set[EV_IRQ_WAKE] = (cause == cause_irq_wake);
  end

  // Write-one-to-clear; a new event in the same cycle wins
  wire logic [7:0] next_ev_status = ((ev_status & ~(wr_evst ? wdata_i : ALL_ZERO)) | ev_set) & EV_MASK;
  wire logic [7:0] next_ev_mask   = wr_evmask ? (wdata_i & EV_MASK) : ev_mask;

  // read mux; unimplemented bits and unmapped addresses read zero
  wire logic [7:0] power_reset_status_reg_view = HAS_POWER_RESET_STATUS_REG ? (power_reset_status_reg_o | ({7'h00, parity_en_cfg_i} << POWER_RESET_STATUS_REG_CFG_BIT)) : ALL_ZERO;
  wire logic [7:0] rd_mux =
    (addr_i == ADDR_STATUS)    ? status_o :
    (addr_i == ADDR_POWER_RESET_STATUS_REG)      ? power_reset_status_reg_view :
    (addr_i == ADDR_IRQCON)    ? irq_control_reg_o :
    (addr_i == ADDR_PIR)       ? periph_irq_flag_reg_o :
    (addr_i == ADDR_PIE)       ? periph_irq_enable_reg_o :
    (addr_i == ADDR_OPTION)    ? option_o :
    (addr_i == ADDR_PORTA_DIR) ? port_a_direction_o :
    (addr_i == ADDR_PORTB_DIR) ? port_b_direction_o :
    (addr_i == ADDR_EV_STATUS) ? ev_status :
    (addr_i == ADDR_EV_MASK)   ? ev_mask : ALL_ZERO;

  // Register state and outputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_o                <= ST_RESET;
      power_reset_status_reg_o                  <= HAS_POWER_RESET_STATUS_REG ? POWER_RESET_STATUS_REG_RESET : ALL_ZERO;
      irq_control_reg_o       <= ALL_ZERO;
      periph_irq_flag_reg_o   <= ALL_ZERO;
      periph_irq_enable_reg_o <= ALL_ZERO;
      option_o                <= ALL_ONES;
      port_a_direction_o      <= PORTA_IMPL_MASK;
      port_b_direction_o      <= ALL_ONES;
      ev_status               <= ALL_ZERO;
      ev_mask                 <= ALL_ZERO;
      pc_load_o               <= 1'b0;
      pc_value_o              <= RESET_VECTOR;
      rdata_o                 <= ALL_ZERO;
      irq_o                   <= 1'b0;
    end else begin
      status_o                <= next_status;
      power_reset_status_reg_o                  <= next_power_reset_status_reg;
      irq_control_reg_o       <= next_irqcon;
      periph_irq_flag_reg_o   <= next_pir;
      periph_irq_enable_reg_o <= next_pie;
      option_o                <= next_option;
      port_a_direction_o      <= next_porta;
      port_b_direction_o      <= next_portb;
      ev_status               <= next_ev_status;
      ev_mask                 <= next_ev_mask;
      pc_load_o               <= (cause != cause_none);
      pc_value_o              <= (cause != cause_none) ? next_pc : pc_value_o;
      rdata_o                 <= rd_i ? rd_mux : ALL_ZERO;
      irq_o                   <= |(next_ev_status & next_ev_mask);
    end
  end

  a_ext_run_load: assert property (@(posedge clk_i) disable iff (reset_i)
    (cause == cause_ext_run) |=> (pc_load_o && pc_value_o == RESET_VECTOR
      && (status_o & ST_BANK_MASK) == ALL_ZERO && power_reset_status_reg_o == $past(power_reset_status_reg_o)
      && status_o[ST_TO_BIT] == $past(status_o[ST_TO_BIT])))
    else $error("pin reset while running loaded wrong state");

  a_ext_sleep_load: assert property (@(posedge clk_i) disable iff (reset_i)
    (cause == cause_ext_sleep && !wr_i) |=> (pc_value_o == RESET_VECTOR && status_o[ST_TO_BIT]
      && !status_o[ST_PD_BIT] && status_o[2:0] == $past(status_o[2:0])))
    else $error("pin reset while asleep loaded wrong state");

  a_irq_wake_next: assert property (@(posedge clk_i) disable iff (reset_i)
    (cause == cause_irq_wake && !global_irq_enable) |=> (pc_load_o && pc_value_o == pc_inc($past(pc_i))
      && status_o[ST_TO_BIT] && !status_o[ST_PD_BIT] && power_reset_status_reg_o == $past(power_reset_status_reg_o)))
    else $error("interrupt wake did not continue at next address");

  a_irq_wake_vector: assert property (@(posedge clk_i) disable iff (reset_i)
    (cause == cause_irq_wake && global_irq_enable) |=> (pc_load_o && pc_value_o == IRQ_VECTOR))
    else $error("interrupt wake did not jump to vector");

  a_wake_flags_kept: assert property (@(posedge clk_i) disable iff (reset_i)
    is_wake |=> ((irq_control_reg_o & $past(wake_irq_bits)) == $past(wake_irq_bits)
      && (periph_irq_flag_reg_o & $past(wake_pir_bits)) == $past(wake_pir_bits)))
    else $error("waking source flag bits not set");

  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i |=> ((rdata_o & ~POWER_RESET_STATUS_REG_IMPL_MASK & ~(ALL_ONES & 8'h80)) == ALL_ZERO || $past(addr_i) != ADDR_POWER_RESET_STATUS_REG)
      && ((port_a_direction_o & ~PORTA_IMPL_MASK) == ALL_ZERO)
      && ((periph_irq_flag_reg_o & ~PIR_IMPL_MASK) == ALL_ZERO))
    else $error("unimplemented bits not zero");

  // reduced build carries no power flags and ignores brown-out
  a_reduced_build: assert property (@(posedge clk_i) disable iff (reset_i)
    (!HAS_POWER_RESET_STATUS_REG && brownout_i && !por_i && !parity_err_i && !external_reset_pin_i
      && !wdt_timeout_i && !irq_wake_i) |=> (!pc_load_o && power_reset_status_reg_o == ALL_ZERO))
    else $error("reduced build reacted to brown-out");

  // power-on flag falls only on power-on reset or a software write
  a_por_flag_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(power_reset_status_reg_o[POWER_RESET_STATUS_REG_POR_BIT]) |-> ($past(cause == cause_por) || $past(wr_power_reset_status_reg)))
    else $error("power-on flag cleared by another cause");

  // parity flag cleared by parity reset, set by power-on
  a_parity_flag: assert property (@(posedge clk_i) disable iff (reset_i || !HAS_POWER_RESET_STATUS_REG)
    ((cause == cause_parity) |=> !power_reset_status_reg_o[POWER_RESET_STATUS_REG_PER_BIT]) and ((cause == cause_por) |=> power_reset_status_reg_o[POWER_RESET_STATUS_REG_PER_BIT]))
    else $error("parity flag not handled by reset");

  a_por_image: assert property (@(posedge clk_i) disable iff (reset_i)
    (cause == cause_por) |=> (pc_value_o == RESET_VECTOR && status_o[ST_TO_BIT] && status_o[ST_PD_BIT]
      && option_o == ALL_ONES && port_b_direction_o == ALL_ONES && !irq_control_reg_o[GIE_BIT]
      && periph_irq_enable_reg_o == ALL_ZERO))
    else $error("power-on image wrong");

  a_wdt_bor_image: assert property (@(posedge clk_i) disable iff (reset_i)
    ((cause == cause_wdt_reset) |=> (!status_o[ST_TO_BIT] && status_o[ST_PD_BIT]))
    and ((cause == cause_bor && !wr_i) |=> (!power_reset_status_reg_o[POWER_RESET_STATUS_REG_BOR_BIT]
      && power_reset_status_reg_o[POWER_RESET_STATUS_REG_PER_BIT:POWER_RESET_STATUS_REG_POR_BIT] == $past(power_reset_status_reg_o[POWER_RESET_STATUS_REG_PER_BIT:POWER_RESET_STATUS_REG_POR_BIT]))))
    else $error("watchdog or brown-out image wrong");

endmodule // rsl_loader

// file: tb/tb.sv
// Self-checking bench for the reset-state loader, full and reduced builds side by side.
// Assumes one clock, one-cycle cause pulses and a register port answering one cycle later.
`timescale 1ns/10ps
module tb
  import rsl_pkg::*;
;
  logic            clk_i;
  logic            reset_i;
  logic [5:0]      cause;  // Order: power-on, brown-out, parity, pin, watchdog, irq
  logic            asleep;
  logic [PC_W-1:0] pcv;
  logic [PC_W-1:0] pr;
  logic            cfg;
  logic [7:0]      wf, wp, fa, fb;
  logic [3:0]      addr;
  logic [7:0]      wdata;
  logic            wr, rd;
  logic [7:0]      rdata, status, pwr, irqcon, pir, pie, option, pa, pb, pwr2;
  logic            pc_load, irq, pc_load2;
  logic [PC_W-1:0] pc_value;
  logic [7:0]      s, v;
  logic            g;
  int              failures, n_checks, seed;
  localparam logic [5:0] CV [0:8] = '{6'h08, 6'h08, 6'h10, 6'h10, 6'h20, 6'h20, 6'h04, 6'h02, 6'h01};

  // Full build and reduced build on the same stimulus
  rsl_loader #(.HAS_POWER_RESET_STATUS_REG(1'b1)) u_rsl_loader (.clk_i(clk_i), .reset_i(reset_i), .por_i(cause[0]),
    .brownout_i(cause[1]), .parity_err_i(cause[2]), .external_reset_pin_i(cause[3]), .wdt_timeout_i(cause[4]),
    .irq_wake_i(cause[5]), .asleep_i(asleep), .pc_i(pcv), .parity_en_cfg_i(cfg), .wake_irq_flags_i(wf),
    .wake_periph_flags_i(wp), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .pc_load_o(pc_load), .pc_value_o(pc_value), .status_o(status), .power_reset_status_reg_o(pwr), .irq_control_reg_o(irqcon),
    .periph_irq_flag_reg_o(pir), .periph_irq_enable_reg_o(pie), .option_o(option), .port_a_direction_o(pa),
    .port_b_direction_o(pb), .irq_o(irq));
  rsl_loader #(.HAS_POWER_RESET_STATUS_REG(1'b0)) u_rsl_loader_lite (.clk_i(clk_i), .reset_i(reset_i), .por_i(cause[0]),
    .brownout_i(cause[1]), .parity_err_i(cause[2]), .external_reset_pin_i(cause[3]), .wdt_timeout_i(cause[4]),
    .irq_wake_i(cause[5]), .asleep_i(asleep), .pc_i(pcv), .parity_en_cfg_i(cfg), .wake_irq_flags_i(wf),
    .wake_periph_flags_i(wp), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(),
    .pc_load_o(pc_load2), .pc_value_o(), .status_o(), .power_reset_status_reg_o(pwr2), .irq_control_reg_o(),
    .periph_irq_flag_reg_o(), .periph_irq_enable_reg_o(), .option_o(), .port_a_direction_o(),
    .port_b_direction_o(), .irq_o());

  // Expected status after each cause kind
  function automatic logic [7:0] exp_st(input int k, input logic [7:0] x);
    case (k)
      0:       exp_st = x & 8'h1f;
      1:       exp_st = (x & 8'h07) | 8'h10;
      4, 6:    exp_st = (x & 8'he7) | 8'h10;
      2:       exp_st = (x & 8'h07) | 8'h08;
      3:       exp_st = x & 8'he7;
      7, 8:    exp_st = (x & 8'h07) | 8'h18;
      default: exp_st = x;
    endcase
  endfunction

  // Expected program counter target
  function automatic logic [PC_W-1:0] exp_pc(input int k, input logic en, input logic [PC_W-1:0] p);
    exp_pc = (k == 3 || k == 4) ? p + PC_STEP : RESET_VECTOR;
    if (k == 4 && en) exp_pc = IRQ_VECTOR;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] ev);
    begin
      n_checks++;
      if (seen !== ev) begin
        failures++;
        $display("Error at %0t: seen %h expected %h", $time, seen, ev);
      end
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    begin
      @(posedge clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      #1;
    end
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] ev);
    begin
      @(posedge clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk(rdata, ev);
    end
  endtask

  // One cause pulse, then the load target, status and reduced-build reaction
  task automatic fire(input int k, input logic slp, input string nm);
    logic [PC_W-1:0] ep;
    begin
      ep = exp_pc(k, g, pr);
      s  = exp_st(k, s);
      @(posedge clk_i);
      asleep <= slp;
      pcv    <= pr;
      wf     <= (k == 4) ? fa : ALL_ZERO;
      wp     <= (k == 4) ? fb : ALL_ZERO;
      cause  <= CV[k];
      @(posedge clk_i);
      cause <= 6'h00;
      #1;
      chk(pc_load, k != 5);
      if (k != 5) chk(pc_value, ep);
      chk(k == 8 ? status & 8'hf8 : status, k == 8 ? 8'h18 : s);
      chk(pc_load2, k != 5 && k != 7);
      $display("test %s done", nm);
    end
  endtask

  task automatic stop_test;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask

  // Clock of 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk_i);
    $display("Error at %0t: watchdog expired", $time);
    failures++;
    stop_test;
  end

  // Main sequence
  initial begin
    seed = 76; failures = 0; n_checks = 0; reset_i = 1'b1; cause = 6'h00; asleep = 1'b0;
    pcv = '0; cfg = 1'b1; wf = 8'h00; wp = 8'h00; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; g = 1'b0;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(status, ST_RESET);
    chk(pwr, POWER_RESET_STATUS_REG_RESET);
    chk(pwr2, ALL_ZERO);
    chk(option, ALL_ONES);
    chk(pa, PORTA_IMPL_MASK);
    chk(pb, ALL_ONES);
    chk(irq, 1'b0);
    $display("test reset done");
    v = 8'($random(seed));
    wr_reg(ADDR_STATUS, v);
    s = (v & ST_WR_MASK) | ST_RESET;
    chk(status, s);
    wr_reg(ADDR_OPTION, v ^ 8'h5a);
    rd_reg(ADDR_OPTION, v ^ 8'h5a);
    rd_reg(4'hf, ALL_ZERO);
    wr_reg(ADDR_POWER_RESET_STATUS_REG, ALL_ONES);
    rd_reg(ADDR_POWER_RESET_STATUS_REG, 8'h87);
    chk(pwr2, ALL_ZERO);
    wr_reg(ADDR_PORTA_DIR, ALL_ONES);
    rd_reg(ADDR_PORTA_DIR, PORTA_IMPL_MASK);
    pr = PC_W'($random(seed));
    fa = 8'($random(seed));
    fb = 8'($random(seed));
    fire(0, 1'b0, "pin_run");
    chk(option, ALL_ONES);
    chk(pwr, POWER_RESET_STATUS_REG_IMPL_MASK);
    fire(1, 1'b1, "pin_sleep");
    fire(2, 1'b0, "watchdog_reset");
    fire(3, 1'b1, "watchdog_wake");
    wr_reg(ADDR_IRQCON, ALL_ZERO);
    fire(4, 1'b1, "irq_wake");
    chk(irqcon, fa & IRQCON_FLAG_MASK);
    chk(pir, fb & PIR_IMPL_MASK);
    wr_reg(ADDR_IRQCON, 8'h80);
    g = 1'b1;
    fire(4, 1'b1, "irq_vector");
    fire(5, 1'b0, "irq_awake");
    fire(6, 1'b0, "parity");
    chk(pwr & POWER_RESET_STATUS_REG_IMPL_MASK, 8'h03);
    fire(7, 1'b0, "brownout");
    chk(pwr & POWER_RESET_STATUS_REG_IMPL_MASK, 8'h02);
    chk(pwr2, ALL_ZERO);
    wr_reg(ADDR_POWER_RESET_STATUS_REG, ALL_ONES);
    wr_reg(ADDR_PIE, ALL_ONES);
    wr_reg(ADDR_IRQCON, 8'h80);
    wr_reg(ADDR_PORTA_DIR, ALL_ZERO);
    wr_reg(ADDR_PORTB_DIR, v);
    wr_reg(ADDR_PIR, ALL_ONES);
    rd_reg(ADDR_PIR, PIR_IMPL_MASK);
    fire(8, 1'b0, "power_on");
    chk(pb, ALL_ONES);
    chk(pir, ALL_ZERO);
    cfg <= 1'b0;
    rd_reg(ADDR_POWER_RESET_STATUS_REG, 8'h05);
    chk(pwr & POWER_RESET_STATUS_REG_IMPL_MASK, 8'h05);
    chk(pie, ALL_ZERO);
    chk(irqcon[GIE_BIT], 1'b0);
    chk(pa, PORTA_IMPL_MASK);
    rd_reg(ADDR_EV_STATUS, EV_MASK);
    chk(irq, 1'b0);
    wr_reg(ADDR_EV_MASK, 8'h08);
    @(posedge clk_i);
    #1;
    chk(irq, 1'b1);
    wr_reg(ADDR_EV_STATUS, 8'h08);
    @(posedge clk_i);
    #1;
    chk(irq, 1'b0);
    rd_reg(ADDR_EV_STATUS, 8'h77);
    $display("test events done");
    stop_test;
  end
endmodule // tb
